// ==== verilog/flow_pkg.sv ====
package flow_pkg;

  // Program counter and vector
  localparam int PC_W = 10;
  localparam logic [PC_W-1:0] PC_RESET = 10'h000;
  localparam logic [PC_W-1:0] VECTOR = {PC_W{1'b1}};
  localparam int STACK_DEPTH = 31;

  // Sequencing operation codes from the decoder
  localparam logic [2:0] OP_SEQ = 3'h0;
  localparam logic [2:0] OP_JUMP = 3'h1;
  localparam logic [2:0] OP_CALL = 3'h2;
  localparam logic [2:0] OP_RETURN = 3'h3;
  localparam logic [2:0] OP_RETURN_FROM_ISR = 3'h4;
  localparam logic [2:0] OP_INT_ENABLE = 3'h5;
  localparam logic [2:0] OP_INT_DISABLE = 3'h6;

  // Condition codes
  localparam logic [2:0] COND_ALWAYS = 3'h0;
  localparam logic [2:0] COND_CARRY_SET = 3'h1;
  localparam logic [2:0] COND_CARRY_CLEAR = 3'h2;
  localparam logic [2:0] COND_ZERO_SET = 3'h3;
  localparam logic [2:0] COND_ZERO_CLEAR = 3'h4;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ERR = 8'h08;
  localparam logic [7:0] REG_IRQ_COUNT = 8'h0c;

  // Field positions and reset values
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_SRST_BIT = 1;
  localparam logic CTRL_RUN_RESET = 1'b1;
  localparam int ST_ZERO_BIT = 16;
  localparam int ST_CARRY_BIT = 17;
  localparam int ST_IE_BIT = 18;
  localparam int ST_ISR_BIT = 19;
  localparam int ST_LEVEL_LSB = 24;
  localparam int ERR_OVF_BIT = 0;
  localparam int ERR_UNF_BIT = 1;
  localparam int IRQ_COUNT_W = 16;

  // AHB transfer type bit that marks an active transfer
  localparam int HTRANS_ACTIVE_BIT = 1;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_FETCH = 4'b0001,
    ST_EXEC = 4'b0010,
    ST_IENT0 = 4'b0100,
    ST_IENT1 = 4'b1000
  } seq_state_t;

endpackage

// ==== verilog/call_stack.sv ====
`timescale 1ns/1ps
module call_stack #(
  parameter int W = 10,
  parameter int DEPTH = 31,
  parameter int LVL_W = $clog2(DEPTH + 1)
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic clr,
  input wire logic push,
  input wire logic pop,
  input wire logic [W-1:0] push_data,
  output logic [W-1:0] top,
  output logic [LVL_W-1:0] level,
  output logic overflow,
  output logic underflow
);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [LVL_W-1:0] lvl;
  } stack_state_t;

  stack_state_t q;
  stack_state_t d;

  localparam logic [LVL_W-1:0] FULL = LVL_W'(DEPTH);

  // Top entry, zero when empty
  always_comb begin
    top = '0;
    if (q.lvl != '0) begin
      top = q.mem[q.lvl - 1'b1];
    end
  end

  assign level = q.lvl;
  assign overflow = push & (q.lvl == FULL);
  assign underflow = pop & (q.lvl == '0);

  // Push at full is dropped, pop at empty leaves level at zero
  always_comb begin
    d = q;
    if (clr) begin
      d.lvl = '0;
    end else if (push && q.lvl != FULL) begin
      d.mem[q.lvl] = push_data;
      d.lvl = q.lvl + 1'b1;
    end else if (pop && q.lvl != '0) begin
      d.lvl = q.lvl - 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

endmodule

// ==== verilog/program_flow.sv ====
// Local design decisions: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
// Behaviour
// - Program counter steps by one after each instruction unless flow changes.
// - Reset event sets program counter to zero.
// - Jump, call, return honour none, carry set/clear, zero set/clear conditions.
// - Untaken jump changes nothing yet still takes two clock cycles.
// - Taken jump loads target, leaves stack and flags alone.
// - Targets are absolute addresses from the instruction only.
// - Taken call pushes current counter then loads subroutine address.
// - Untaken call takes two cycles and changes nothing.
// - Taken return pops top, adds one, loads counter.
// - Call and return never write zero or carry flags.
// - Interrupt ignored until enabled after reset; disable blocks recognition.
// - Recognised interrupt finishes current instruction then calls the vector.
// - Entry saves flags, clears enable, pushes counter.
// - Pushed address is the preempted instruction, which has not run.
// - Acknowledge is high in the second cycle of interrupt entry.
// - Recognition happens as the address bus moves to the preempted instruction.
// - Vector is the last store location, all ones.
// - Return from interrupt restores flags and pops counter without increment.
// - Return from interrupt enables or leaves disabled per its option.
// - Every instruction takes two clock cycles.
module program_flow #(
  parameter int DEPTH = flow_pkg::STACK_DEPTH
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Decoded instruction, valid in the second cycle
  input wire logic [2:0] instr_op,
  input wire logic [2:0] instr_cond,
  input wire logic [flow_pkg::PC_W-1:0] instr_addr,
  input wire logic instr_ie_opt,
  // Flag results of other instructions
  input wire logic alu_flag_we,
  input wire logic alu_zero,
  input wire logic alu_carry,
  // Interrupt pin and acknowledge
  input wire logic irq,
  output logic irq_ack,
  // Program flow outputs
  output logic [flow_pkg::PC_W-1:0] inst_addr,
  output logic instr_phase2,
  output logic zero,
  output logic carry,
  output logic irq_enabled
);

  localparam int LVL_W = $clog2(DEPTH + 1);

  typedef struct packed {
    flow_pkg::seq_state_t st;
    logic [flow_pkg::PC_W-1:0] pc;
    logic zero;
    logic carry;
    logic ie;
    logic zero_saved;
    logic carry_saved;
    logic in_isr;
    logic irq_meta;
    logic irq_sync;
    logic irq_seen;
    logic ack;
    logic run;
    logic srst;
    logic ovf;
    logic unf;
    logic [flow_pkg::IRQ_COUNT_W-1:0] irq_count;
    logic wr;
    logic [7:0] wa;
    logic [31:0] rdata;
  } flow_state_t;

  flow_state_t q;
  flow_state_t d;

  logic push;
  logic pop;
  logic clr;
  logic [flow_pkg::PC_W-1:0] push_pc;
  logic [flow_pkg::PC_W-1:0] stk_top;
  logic [LVL_W-1:0] stk_level;
  logic stk_ovf;
  logic stk_unf;
  logic access;
  logic met;
  logic [flow_pkg::PC_W-1:0] nxt;

  // Condition check against the current flags
  function automatic logic cond_met(
    input logic [2:0] cond,
    input logic z,
    input logic c
  );
    logic r;
    r = 1'b0;
    case (cond)
      flow_pkg::COND_ALWAYS: r = 1'b1;
      flow_pkg::COND_CARRY_SET: r = c;
      flow_pkg::COND_CARRY_CLEAR: r = ~c;
      flow_pkg::COND_ZERO_SET: r = z;
      flow_pkg::COND_ZERO_CLEAR: r = ~z;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Register read decode
  function automatic logic [31:0] read_word(
    input logic [7:0] off,
    input flow_state_t s,
    input logic [LVL_W-1:0] lvl
  );
    logic [31:0] w;
    w = '0;
    case (off)
      flow_pkg::REG_CTRL: begin
        w[flow_pkg::CTRL_RUN_BIT] = s.run;
      end
      flow_pkg::REG_STATUS: begin
        w[flow_pkg::PC_W-1:0] = s.pc;
        w[flow_pkg::ST_ZERO_BIT] = s.zero;
        w[flow_pkg::ST_CARRY_BIT] = s.carry;
        w[flow_pkg::ST_IE_BIT] = s.ie;
        w[flow_pkg::ST_ISR_BIT] = s.in_isr;
        w[flow_pkg::ST_LEVEL_LSB +: LVL_W] = lvl;
      end
      flow_pkg::REG_ERR: begin
        w[flow_pkg::ERR_OVF_BIT] = s.ovf;
        w[flow_pkg::ERR_UNF_BIT] = s.unf;
      end
      flow_pkg::REG_IRQ_COUNT: begin
        w[flow_pkg::IRQ_COUNT_W-1:0] = s.irq_count;
      end
      default: w = '0;
    endcase
    return w;
  endfunction

  call_stack #(
    .W(flow_pkg::PC_W),
    .DEPTH(DEPTH),
    .LVL_W(LVL_W)
  ) u_stack (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .clr(clr),
    .push(push),
    .pop(pop),
    .push_data(push_pc),
    .top(stk_top),
    .level(stk_level),
    .overflow(stk_ovf),
    .underflow(stk_unf)
  );

  // Bus answers with no wait states unless frozen
  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign hrdata = q.rdata;
  assign access = hsel & hready & htrans[flow_pkg::HTRANS_ACTIVE_BIT];

  // Outputs straight from state
  assign inst_addr = q.pc;
  assign instr_phase2 = (q.st == flow_pkg::ST_EXEC);
  assign zero = q.zero;
  assign carry = q.carry;
  assign irq_enabled = q.ie;
  assign irq_ack = q.ack;

  // Next-state logic
  always_comb begin
    d = q;
    push = 1'b0;
    pop = 1'b0;
    clr = 1'b0;
    push_pc = q.pc;
    met = cond_met(instr_cond, q.zero, q.carry);
    nxt = q.pc + 1'b1;
    d.ack = 1'b0;
    d.srst = 1'b0;

    // Interrupt pin synchroniser
    d.irq_meta = irq;
    d.irq_sync = q.irq_meta;

    // Bus address phase and read data
    d.wr = access & hwrite;
    if (access) begin
      d.wa = haddr[7:0];
    end
    if (access && !hwrite) begin
      d.rdata = read_word(haddr[7:0], q, stk_level);
    end

    // Bus data phase
    if (q.wr) begin
      case (q.wa)
        flow_pkg::REG_CTRL: begin
          d.run = hwdata[flow_pkg::CTRL_RUN_BIT];
          d.srst = hwdata[flow_pkg::CTRL_SRST_BIT];
        end
        flow_pkg::REG_ERR: begin
          if (hwdata[flow_pkg::ERR_OVF_BIT]) begin
            d.ovf = 1'b0;
          end
          if (hwdata[flow_pkg::ERR_UNF_BIT]) begin
            d.unf = 1'b0;
          end
        end
        default: d.run = q.run;
      endcase
    end

    // Pending request latched only while enabled
    d.irq_seen = (q.irq_seen | q.irq_sync) & q.ie;

    // Sequencer
    case (q.st)
      flow_pkg::ST_FETCH: begin
        if (q.run) begin
          d.st = flow_pkg::ST_EXEC;
        end
      end
      flow_pkg::ST_EXEC: begin
        case (instr_op)
          flow_pkg::OP_JUMP: begin
            if (met) begin
              nxt = instr_addr;
            end
          end
          flow_pkg::OP_CALL: begin
            if (met) begin
              push = 1'b1;
              push_pc = q.pc;
              nxt = instr_addr;
            end
          end
          flow_pkg::OP_RETURN: begin
            if (met) begin
              pop = 1'b1;
              nxt = stk_top + 1'b1;
            end
          end
          flow_pkg::OP_RETURN_FROM_ISR: begin
            pop = 1'b1;
            nxt = stk_top;
            d.zero = q.zero_saved;
            d.carry = q.carry_saved;
            d.ie = instr_ie_opt;
            d.in_isr = 1'b0;
          end
          flow_pkg::OP_INT_ENABLE: begin
            d.ie = 1'b1;
          end
          flow_pkg::OP_INT_DISABLE: begin
            d.ie = 1'b0;
          end
          default: begin
            // Only ordinary instructions write ALU results to the flags
            if (alu_flag_we) begin
              d.zero = alu_zero;
              d.carry = alu_carry;
            end
          end
        endcase
        d.pc = nxt;
        // Recognise as the address moves to the preempted instruction
        if (q.irq_seen && d.ie) begin
          d.st = flow_pkg::ST_IENT0;
        end else begin
          d.st = flow_pkg::ST_FETCH;
        end
      end
      flow_pkg::ST_IENT0: begin
        push = 1'b1;
        push_pc = q.pc;
        d.zero_saved = q.zero;
        d.carry_saved = q.carry;
        d.ie = 1'b0;
        d.irq_seen = 1'b0;
        d.in_isr = 1'b1;
        d.irq_count = q.irq_count + 1'b1;
        d.ack = 1'b1;
        d.st = flow_pkg::ST_IENT1;
      end
      flow_pkg::ST_IENT1: begin
        d.pc = flow_pkg::VECTOR;
        d.st = flow_pkg::ST_FETCH;
      end
      default: begin
        d.st = flow_pkg::ST_FETCH;
      end
    endcase

    // Sticky stack errors, set wins over clear
    if (stk_ovf) begin
      d.ovf = 1'b1;
    end
    if (stk_unf) begin
      d.unf = 1'b1;
    end

    // Software reset event
    if (q.srst) begin
      clr = 1'b1;
      push = 1'b0;
      pop = 1'b0;
      d.pc = flow_pkg::PC_RESET;
      d.st = flow_pkg::ST_FETCH;
      d.ie = 1'b0;
      d.irq_seen = 1'b0;
      d.ack = 1'b0;
      d.in_isr = 1'b0;
      d.zero = 1'b0;
      d.carry = 1'b0;
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.st <= flow_pkg::ST_FETCH;
      q.pc <= flow_pkg::PC_RESET;
      q.run <= flow_pkg::CTRL_RUN_RESET;
    end else if (ce) begin
      q <= d;
    end
  end

endmodule

// ==== sim/program_flow_monitor.sv ====
`timescale 1ns/1ps
module program_flow_monitor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic [2:0] instr_op,
  input wire logic [2:0] instr_cond,
  input wire logic [9:0] instr_addr,
  input wire logic irq_ack,
  input wire logic [9:0] inst_addr,
  input wire logic instr_phase2,
  input wire logic zero,
  input wire logic carry,
  input wire logic irq_enabled
);
  logic ex;
  logic ok;
  logic br;
  // Instruction end, branch kind and condition outcome
  assign ex = instr_phase2 && ce;
  assign br = instr_op inside {flow_pkg::OP_JUMP, flow_pkg::OP_CALL, flow_pkg::OP_RETURN};
  assign ok = instr_cond == flow_pkg::COND_ALWAYS
    || (instr_cond == flow_pkg::COND_CARRY_SET && carry)
    || (instr_cond == flow_pkg::COND_CARRY_CLEAR && !carry)
    || (instr_cond == flow_pkg::COND_ZERO_SET && zero)
    || (instr_cond == flow_pkg::COND_ZERO_CLEAR && !zero);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_entry;
    irq_ack && ce ##1 inst_addr == flow_pkg::VECTOR;
  endsequence
  sequence s_load;
    ex && ok && br && instr_op != flow_pkg::OP_RETURN;
  endsequence
  AST_RESET_PC: assert property ($rose(hresetn) |-> inst_addr == flow_pkg::PC_RESET)
    else $error("pc not cleared");
  AST_VECTOR: assert property (irq_ack && ce |-> s_entry)
    else $error("no vector");
  AST_ACK: assert property (irq_ack && ce |-> !irq_enabled ##1 !irq_ack)
    else $error("bad ack");
  AST_LOAD: assert property (s_load |=> inst_addr == $past(instr_addr))
    else $error("bad target");
  AST_UNTAKEN: assert property (ex && !ok && br |=>
    inst_addr == $past(inst_addr) + 1'b1) else $error("untaken moved");
  AST_SEQ: assert property (ex && instr_op == flow_pkg::OP_SEQ |=>
    inst_addr == $past(inst_addr) + 1'b1) else $error("no step");
  AST_FLAGS: assert property (ex && br |=> $stable({zero, carry}))
    else $error("flags written");
  AST_DIS: assert property (ex && instr_op == flow_pkg::OP_INT_DISABLE |=> !irq_enabled)
    else $error("still enabled");
endmodule

bind program_flow program_flow_monitor mon (.hclk(hclk), .hresetn(hresetn), .ce(ce),
  .instr_op(instr_op), .instr_cond(instr_cond), .instr_addr(instr_addr), .irq_ack(irq_ack),
  .inst_addr(inst_addr), .instr_phase2(instr_phase2), .zero(zero), .carry(carry),
  .irq_enabled(irq_enabled));

// ==== sim/irq_source.sv ====
`timescale 1ns/1ps
module irq_source (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic req,
  input wire logic late,
  input wire logic irq_ack,
  output logic irq
);
  logic ack_q;
  // Request held until acknowledged, cleared a cycle later when slow
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0; // Low when idle
      ack_q <= 1'b0;
    end else begin
      ack_q <= irq_ack;
      if (late ? ack_q : irq_ack) irq <= 1'b0;
      else if (req) irq <= 1'b1; // Held high until acknowledged
    end
  end
endmodule

// ==== sim/program_flow_tb.sv ====
`timescale 1ns/1ps
module program_flow_tb;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [31:0] seed = 32'ha8bb;
  logic [2:0] instr_op = 3'h0, instr_cond = 3'h0, cd;
  logic [9:0] instr_addr = 10'h000, inst_addr, pc = 10'h000;
  logic instr_ie_opt = 1'b0, alu_flag_we = 1'b0, alu_zero = 1'b0, alu_carry = 1'b0;
  logic irq, irq_ack, instr_phase2, zero, carry, irq_enabled, ex, ak, sz, sc;
  logic irq_req = 1'b0, late = 1'b0, track = 1'b1, z_m = 1'b0, c_m = 1'b0, ie_m = 1'b0;
  logic [9:0] stk[$];
  logic [12:0] q[$];
  logic [12:0] e, g;
  int n_mismatch = 0;
  int check_count = 0;

  program_flow uut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .instr_op(instr_op),
    .instr_cond(instr_cond), .instr_addr(instr_addr), .instr_ie_opt(instr_ie_opt),
    .alu_flag_we(alu_flag_we), .alu_zero(alu_zero), .alu_carry(alu_carry), .irq(irq),
    .irq_ack(irq_ack), .inst_addr(inst_addr), .instr_phase2(instr_phase2), .zero(zero),
    .carry(carry), .irq_enabled(irq_enabled));
  irq_source partner (.hclk(hclk), .hresetn(hresetn), .req(irq_req), .late(late),
    .irq_ack(irq_ack), .irq(irq));

  // Clock
  initial forever #2 hclk = ~hclk;

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] ev, input logic [31:0] gv);
    check_count++;
    if (gv !== ev) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", nm, ev, gv);
    end
  endtask

  function automatic logic [9:0] pop();
    if (stk.size() == 0) return 10'h000;
    return stk.pop_back();
  endfunction

  function automatic logic taken(input logic [2:0] c);
    case (c)
      flow_pkg::COND_CARRY_SET: return c_m;
      flow_pkg::COND_CARRY_CLEAR: return !c_m;
      flow_pkg::COND_ZERO_SET: return z_m;
      flow_pkg::COND_ZERO_CLEAR: return !z_m;
      default: return 1'b1;
    endcase
  endfunction

  // One instruction: drive it, wait for its second cycle, note the outcome
  task automatic exec(input logic [2:0] op, input logic [2:0] c, input logic opt, input logic we);
    int n;
    r = $random(seed);
    instr_op <= op;
    instr_cond <= c;
    instr_addr <= r[9:0];
    instr_ie_opt <= opt;
    alu_flag_we <= we;
    alu_zero <= r[10];
    alu_carry <= r[11];
    #1;
    for (n = 0; instr_phase2 !== 1'b1; n++) begin
      if (n > 40) begin
        n_mismatch++;
        finish_test();
      end
      @(posedge hclk);
      #1;
    end
    if (op == flow_pkg::OP_RETURN_FROM_ISR) begin
      pc = pop();
      {z_m, c_m, ie_m} = {sz, sc, opt};
    end else if (op inside {flow_pkg::OP_JUMP, flow_pkg::OP_CALL, flow_pkg::OP_RETURN}
        && taken(c)) begin
      if (op == flow_pkg::OP_CALL) stk.push_back(pc);
      pc = (op == flow_pkg::OP_RETURN) ? pop() + 10'h001 : r[9:0];
    end else begin
      pc++;
      if (we) {z_m, c_m} = {r[10], r[11]};
      ie_m = op == flow_pkg::OP_INT_ENABLE || (ie_m && op != flow_pkg::OP_INT_DISABLE);
    end
    q.push_back({ie_m, z_m, c_m, pc});
    @(posedge hclk);
  endtask

  task automatic rdy;
    int n;
    for (n = 0; n < 20; n++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) return;
    end
    n_mismatch++;
    finish_test();
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    r = hrdata;
    check("resp", 32'h0, {31'h0, hresp});
  endtask

  // Checks each finished instruction and follows interrupt entry
  initial forever begin
    @(posedge hclk);
    ex = instr_phase2 && track;
    ak = irq_ack;
    #1;
    if (ex) begin
      e = q.size() ? q.pop_front() : 13'h1fff;
      g = {irq_enabled, zero, carry, inst_addr};
      check("flow", e, g);
    end
    if (ak) begin
      check("ack_ie", 32'h1, {31'h0, ie_m});
      check("vector", flow_pkg::VECTOR, inst_addr);
      stk.push_back(pc);
      {sz, sc, ie_m, pc} = {z_m, c_m, 1'b0, flow_pkg::VECTOR};
    end
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    exec(flow_pkg::OP_RETURN, flow_pkg::COND_ALWAYS, 1'b0, 1'b0);
    repeat (4) for (cd = flow_pkg::COND_ALWAYS; cd <= flow_pkg::COND_ZERO_CLEAR; cd++) begin
      exec(flow_pkg::OP_SEQ, cd, 1'b0, 1'b1);
      exec(flow_pkg::OP_JUMP, cd, 1'b0, 1'b0);
      exec(flow_pkg::OP_CALL, cd, 1'b0, 1'b0);
      exec(flow_pkg::OP_RETURN, cd, 1'b0, 1'b0);
    end
    irq_req <= 1'b1;
    repeat (4) exec(flow_pkg::OP_SEQ, cd, 1'b0, 1'b1);
    exec(flow_pkg::OP_INT_ENABLE, cd, 1'b0, 1'b0);
    irq_req <= 1'b0;
    repeat (4) exec(flow_pkg::OP_SEQ, cd, 1'b0, 1'b1);
    exec(flow_pkg::OP_RETURN_FROM_ISR, cd, 1'b1, 1'b0);
    late <= 1'b1;
    exec(flow_pkg::OP_INT_DISABLE, cd, 1'b0, 1'b0);
    irq_req <= 1'b1;
    repeat (3) exec(flow_pkg::OP_SEQ, cd, 1'b0, 1'b1);
    exec(flow_pkg::OP_INT_ENABLE, cd, 1'b0, 1'b0);
    irq_req <= 1'b0;
    repeat (4) exec(flow_pkg::OP_SEQ, cd, 1'b0, 1'b1);
    exec(flow_pkg::OP_RETURN_FROM_ISR, cd, 1'b0, 1'b0);
    exec(flow_pkg::OP_SEQ, cd, 1'b0, 1'b0);
    track <= 1'b0;
    ahb(1'b0, flow_pkg::REG_CTRL, 32'h0);
    check("ctrl", 32'h1, r);
    ahb(1'b0, flow_pkg::REG_ERR, 32'h0);
    check("err", 32'h1 << flow_pkg::ERR_UNF_BIT, r);
    ahb(1'b1, flow_pkg::REG_ERR, 32'h1 << flow_pkg::ERR_UNF_BIT);
    ahb(1'b0, flow_pkg::REG_ERR, 32'h0);
    check("err_clr", 32'h0, r);
    ahb(1'b0, flow_pkg::REG_IRQ_COUNT, 32'h0);
    check("irq_count", 32'h2, r);
    ahb(1'b0, 8'h10, 32'h0);
    check("unmapped", 32'h0, r);
    // Status word with the free-running counter masked out
    ahb(1'b0, flow_pkg::REG_STATUS, 32'h0);
    check("status", (32'(stk.size()) << flow_pkg::ST_LEVEL_LSB) | ({29'h0, ie_m, c_m, z_m} << flow_pkg::ST_ZERO_BIT), r & ~32'h3ff);
    // Halt, then a software reset event clears counter, flags, enable and stack
    ahb(1'b1, flow_pkg::REG_CTRL, 32'h0);
    ahb(1'b1, flow_pkg::REG_CTRL, 32'h1 << flow_pkg::CTRL_SRST_BIT);
    ahb(1'b0, flow_pkg::REG_CTRL, 32'h0);
    check("ctrl_off", 32'h0, r);
    ahb(1'b0, flow_pkg::REG_STATUS, 32'h0);
    check("status_rst", 32'h0, r);
    finish_test();
  end
endmodule
